// *** logic/dfr_register_map.sv ***
`timescale 1ns/100ps
`default_nettype none
module dfr_register_map #(
  parameter int PER_GROUP = 20,
  parameter logic [dfr_pkg::GROUP_COUNT*PER_GROUP-1:0] RUN_LOCK_MASK = '0
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Link request and answer
  input  wire dfr_pkg::dfr_req_t    req,
  output dfr_pkg::dfr_resp_t        resp,
  // Drive monitoring values
  input  wire dfr_pkg::dfr_monitor_t mon,
  // Drive side of the ramp and parameter store
  output logic [15:0]               rampTime,
  output logic                      rampFromLink,
  input  wire logic [$clog2(dfr_pkg::GROUP_COUNT*PER_GROUP)-1:0] drvParamIdx,
  output logic [15:0]               drvParamData
);

  localparam int NP   = dfr_pkg::GROUP_COUNT * PER_GROUP;
  localparam int IDXW = $clog2(NP);
  localparam logic [15:0] PER_GROUP_W = 16'(PER_GROUP);

  logic       rstMeta;
  logic       rstSyncN;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  logic [15:0] rampTime_q;
  logic [15:0] paramMem_q [NP];
  dfr_pkg::dfr_resp_t resp_q;
  dfr_pkg::dfr_resp_t resp_d;
  logic [15:0] drvParamData_q;

  // Request decode
  wire        isRead   = req.func == dfr_pkg::FC_READ_MULTI;
  wire        isMulti  = req.func == dfr_pkg::FC_WRITE_MULTI;
  wire        isWrite  = (req.func == dfr_pkg::FC_WRITE_SINGLE) || isMulti;
  wire        rampHit  = req.regNum == dfr_pkg::REG_RAMP_TIME;
  wire [15:0] grpNum   = req.regNum / dfr_pkg::PARAM_STRIDE;
  wire [15:0] idxNum   = req.regNum % dfr_pkg::PARAM_STRIDE;
  wire        inParam  = (grpNum >= dfr_pkg::PARAM_GROUP_FIRST) && (grpNum <= dfr_pkg::PARAM_GROUP_LAST)
                         && (idxNum != 16'h0000) && (idxNum <= PER_GROUP_W);
  wire        linkOwn  = (req.regNum == dfr_pkg::REG_NODE_ADDRESS) || (req.regNum == dfr_pkg::REG_LINK_BAUD)
                         || (req.regNum == dfr_pkg::REG_LINK_FORMAT);
  wire        paramOk  = inParam && !linkOwn;
  wire [15:0] flatFull = (grpNum - dfr_pkg::PARAM_GROUP_FIRST) * PER_GROUP_W + idxNum - 16'h0001;
  wire [IDXW-1:0] flatIdx = flatFull[IDXW-1:0];

  // Parameter positions of the ramp controls
  localparam logic [15:0] ENABLE_FLAT = (dfr_pkg::REG_RAMP_ENABLE / dfr_pkg::PARAM_STRIDE - 16'h0001)
                                        * PER_GROUP_W + dfr_pkg::REG_RAMP_ENABLE % dfr_pkg::PARAM_STRIDE
                                        - 16'h0001;
  localparam logic [15:0] SELECT_FLAT = (dfr_pkg::REG_RAMP_SELECT / dfr_pkg::PARAM_STRIDE - 16'h0001)
                                        * PER_GROUP_W + dfr_pkg::REG_RAMP_SELECT % dfr_pkg::PARAM_STRIDE
                                        - 16'h0001;
  wire rampWriteOk = paramMem_q[ENABLE_FLAT[IDXW-1:0]] == dfr_pkg::PARAM_ON;
  wire rampSelect  = paramMem_q[SELECT_FLAT[IDXW-1:0]] == dfr_pkg::PARAM_ON;
  wire paramLocked = mon.status.running && RUN_LOCK_MASK[flatIdx];

  // Status word: fault number only while tripped
  wire [7:0]  faultByte  = mon.status.tripped ? mon.faultCode : 8'h00;
  wire [15:0] faultState = {faultByte, mon.status};

  // Live monitor selection, one tap a register
  localparam int NTAP = 17;

  wire [NTAP-1:0]       tapHit;
  wire [NTAP-1:0][15:0] tapData;
  logic [15:0]          monData;
  wire                  monHit = |tapHit;

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_FAULT_STATE)
  ) u_tap_status (
    .regNum  (req.regNum),
    .value   (faultState),
    .hit     (tapHit[0]),
    .tapData (tapData[0])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_OUT_FREQ)
  ) u_tap_freq (
    .regNum  (req.regNum),
    .value   (mon.outFreq),
    .hit     (tapHit[1]),
    .tapData (tapData[1])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_OUT_CURRENT)
  ) u_tap_current (
    .regNum  (req.regNum),
    .value   (mon.outCurrent),
    .hit     (tapHit[2]),
    .tapData (tapData[2])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_OUT_TORQUE)
  ) u_tap_torque (
    .regNum  (req.regNum),
    .value   (mon.outTorque),
    .hit     (tapHit[3]),
    .tapData (tapData[3])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_OUT_POWER)
  ) u_tap_power (
    .regNum  (req.regNum),
    .value   (mon.outPower),
    .hit     (tapHit[4]),
    .tapData (tapData[4])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_INPUT_PINS)
  ) u_tap_pins (
    .regNum  (req.regNum),
    .value   (mon.inputPins),
    .hit     (tapHit[5]),
    .tapData (tapData[5])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_ANALOG_ONE)
  ) u_tap_analog_one (
    .regNum  (req.regNum),
    .value   (mon.analogOne),
    .hit     (tapHit[6]),
    .tapData (tapData[6])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_ANALOG_TWO)
  ) u_tap_analog_two (
    .regNum  (req.regNum),
    .value   (mon.analogTwo),
    .hit     (tapHit[7]),
    .tapData (tapData[7])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_SETPOINT)
  ) u_tap_setpoint (
    .regNum  (req.regNum),
    .value   (mon.setpoint),
    .hit     (tapHit[8]),
    .tapData (tapData[8])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_DC_BUS)
  ) u_tap_dc_bus (
    .regNum  (req.regNum),
    .value   (mon.dcBus),
    .hit     (tapHit[9]),
    .tapData (tapData[9])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_HEATSINK)
  ) u_tap_heatsink (
    .regNum  (req.regNum),
    .value   (mon.heatsink),
    .hit     (tapHit[10]),
    .tapData (tapData[10])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_USER_KWH)
  ) u_tap_user_kwh (
    .regNum  (req.regNum),
    .value   (mon.userKwh),
    .hit     (tapHit[11]),
    .tapData (tapData[11])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_USER_MWH)
  ) u_tap_user_mwh (
    .regNum  (req.regNum),
    .value   (mon.userMwh),
    .hit     (tapHit[12]),
    .tapData (tapData[12])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_LIFE_KWH)
  ) u_tap_life_kwh (
    .regNum  (req.regNum),
    .value   (mon.lifeKwh),
    .hit     (tapHit[13]),
    .tapData (tapData[13])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_LIFE_MWH)
  ) u_tap_life_mwh (
    .regNum  (req.regNum),
    .value   (mon.lifeMwh),
    .hit     (tapHit[14]),
    .tapData (tapData[14])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_RUN_HOURS)
  ) u_tap_run_hours (
    .regNum  (req.regNum),
    .value   (mon.runHours),
    .hit     (tapHit[15]),
    .tapData (tapData[15])
  );

  dfr_reg_tap #(
    .REG_NUM (dfr_pkg::REG_RUN_MINSEC)
  ) u_tap_run_minsec (
    .regNum  (req.regNum),
    .value   (mon.runMinSec),
    .hit     (tapHit[16]),
    .tapData (tapData[16])
  );

  always_comb
  begin
    monData = 16'h0000;
    for (int k = 0; k < NTAP; k++)
      monData = monData | tapData[k];
  end

  // Answer decision
  logic [7:0] exCode;

  always_comb
  begin
    exCode = dfr_pkg::EX_NONE;
    if (!isRead && !isWrite)
      exCode = dfr_pkg::EX_FUNC;
    else if (isMulti && (req.regNum > dfr_pkg::REG_RAMP_TIME || req.regNum == 16'h0000))
      exCode = dfr_pkg::EX_FUNC;
    else if (isRead)
      exCode = (rampHit || monHit || paramOk) ? dfr_pkg::EX_NONE : dfr_pkg::EX_ADDR;
    else if (rampHit)
    begin
      if (!rampWriteOk)
        exCode = dfr_pkg::EX_REFUSED;
      else if (req.wdata > dfr_pkg::RAMP_MAX)
        exCode = dfr_pkg::EX_VALUE;
    end
    else if (paramOk)
      exCode = paramLocked ? dfr_pkg::EX_REFUSED : dfr_pkg::EX_NONE;
    else
      exCode = dfr_pkg::EX_ADDR;
  end

  wire accepted = req.valid && (exCode == dfr_pkg::EX_NONE);
  wire rampWe   = accepted && isWrite && rampHit;
  wire paramWe  = accepted && isWrite && paramOk;

  // Parameters stored as the scaled integers the link carries
  wire [15:0] paramRead = paramMem_q[flatIdx];
  wire [15:0] readData  = rampHit ? rampTime_q : (monHit ? monData : paramRead);

  always_comb
  begin
    resp_d.valid     = req.valid;
    resp_d.exception = exCode;
    resp_d.rdata     = (req.valid && isRead && exCode == dfr_pkg::EX_NONE) ? readData : 16'h0000;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      resp_q <= '0;
    else
      resp_q <= resp_d;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      rampTime_q <= dfr_pkg::RAMP_RESET;
    else if (rampWe)
      rampTime_q <= req.wdata;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      for (int i = 0; i < NP; i++)
        paramMem_q[i] <= dfr_pkg::PARAM_RESET;
    end
    else if (paramWe)
      paramMem_q[flatIdx] <= req.wdata;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      drvParamData_q <= 16'h0000;
    else
      drvParamData_q <= paramMem_q[drvParamIdx];
  end

  assign resp         = resp_q;
  assign rampTime     = rampTime_q;
  assign rampFromLink = rampSelect;
  assign drvParamData = drvParamData_q;

endmodule // dfr_register_map

// One monitoring register: hit flag and its value, zero when not hit
module dfr_reg_tap #(
  parameter logic [15:0] REG_NUM = 16'h0000
) (
  // Request register number
  input  wire logic [15:0] regNum,
  // Live value
  input  wire logic [15:0] value,
  // Selection
  output logic             hit,
  output logic [15:0]      tapData
);

  assign hit     = regNum == REG_NUM;
  assign tapData = hit ? value : 16'h0000;

endmodule // dfr_reg_tap
`default_nettype wire

// *** logic/dfr_pkg.sv ***
`default_nettype none
package dfr_pkg;

  // Function codes and exception answers
  localparam logic [7:0] FC_READ_MULTI   = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI  = 8'h10;
  localparam logic [7:0] EX_NONE         = 8'h00;
  localparam logic [7:0] EX_FUNC         = 8'h01;
  localparam logic [7:0] EX_ADDR         = 8'h02;
  localparam logic [7:0] EX_VALUE        = 8'h03;
  localparam logic [7:0] EX_REFUSED      = 8'h04;

  // Register numbers
  localparam logic [15:0] REG_RAMP_TIME   = 16'h0004;
  localparam logic [15:0] REG_FAULT_STATE = 16'h0006;
  localparam logic [15:0] REG_OUT_FREQ    = 16'h0007;
  localparam logic [15:0] REG_OUT_CURRENT = 16'h0008;
  localparam logic [15:0] REG_OUT_TORQUE  = 16'h0009;
  localparam logic [15:0] REG_OUT_POWER   = 16'h000a;
  localparam logic [15:0] REG_INPUT_PINS  = 16'h000b;
  localparam logic [15:0] REG_ANALOG_ONE  = 16'h0014;
  localparam logic [15:0] REG_ANALOG_TWO  = 16'h0015;
  localparam logic [15:0] REG_SETPOINT    = 16'h0016;
  localparam logic [15:0] REG_DC_BUS      = 16'h0017;
  localparam logic [15:0] REG_HEATSINK    = 16'h0018;
  localparam logic [15:0] REG_USER_KWH    = 16'h001e;
  localparam logic [15:0] REG_USER_MWH    = 16'h001f;
  localparam logic [15:0] REG_LIFE_KWH    = 16'h0020;
  localparam logic [15:0] REG_LIFE_MWH    = 16'h0021;
  localparam logic [15:0] REG_RUN_HOURS   = 16'h0022;
  localparam logic [15:0] REG_RUN_MINSEC  = 16'h0023;

  // Parameter map: register = group * stride + index
  localparam logic [15:0] PARAM_STRIDE      = 16'h0064;
  localparam logic [15:0] PARAM_GROUP_FIRST = 16'h0001;
  localparam logic [15:0] PARAM_GROUP_LAST  = 16'h0005;
  localparam int          GROUP_COUNT       = 5;
  localparam logic [15:0] REG_NODE_ADDRESS  = 16'h01f5;
  localparam logic [15:0] REG_LINK_BAUD     = 16'h01f7;
  localparam logic [15:0] REG_LINK_FORMAT   = 16'h01f8;
  localparam logic [15:0] REG_RAMP_ENABLE   = 16'h01fb;
  localparam logic [15:0] REG_RAMP_SELECT   = 16'h01fc;
  localparam logic [15:0] PARAM_ON          = 16'h0001;

  // Ramp time limits, hundredths of a second
  localparam logic [15:0] RAMP_MAX   = 16'hea60;
  localparam logic [15:0] RAMP_RESET = 16'h0bb8;
  localparam logic [15:0] PARAM_RESET = 16'h0000;

  // Status byte, bit 0 is running
  typedef struct packed {
    logic loadAlarm;
    logic ready;
    logic standby;
    logic serviceDue;
    logic inhibit;
    logic handMode;
    logic tripped;
    logic running;
  } dfr_status_t;

  typedef struct packed {
    dfr_status_t status;
    logic [7:0]  faultCode;
    logic [15:0] outFreq;
    logic [15:0] outCurrent;
    logic [15:0] outTorque;
    logic [15:0] outPower;
    logic [15:0] inputPins;
    logic [15:0] analogOne;
    logic [15:0] analogTwo;
    logic [15:0] setpoint;
    logic [15:0] dcBus;
    logic [15:0] heatsink;
    logic [15:0] userKwh;
    logic [15:0] userMwh;
    logic [15:0] lifeKwh;
    logic [15:0] lifeMwh;
    logic [15:0] runHours;
    logic [15:0] runMinSec;
  } dfr_monitor_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] regNum;
    logic [15:0] wdata;
  } dfr_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  exception;
    logic [15:0] rdata;
  } dfr_resp_t;

endpackage
`default_nettype wire

// *** tb/dfr_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dfr_master_model (
  // Clock
  input  wire logic               clk_sys,
  // Link
  output dfr_pkg::dfr_req_t       req,
  input  wire dfr_pkg::dfr_resp_t resp
);
  initial req = '{valid: 1'b0, func: 8'hff, regNum: 16'hffff, wdata: 16'hffff};
  // One register a call; released fields show the inverse
  task automatic xfer(input logic [7:0] f, input logic [15:0] r, input logic [15:0] w,
                      output logic [7:0] e, output logic [15:0] d);
    @(negedge clk_sys);
    req <= '{valid: 1'b1, func: f, regNum: r, wdata: w};
    @(negedge clk_sys);
    // Answer stands only the cycle after the taking edge
    e = resp.valid ? resp.exception : 8'hee;
    d = resp.rdata;
    req <= '{valid: 1'b0, func: ~f, regNum: ~r, wdata: ~w};
  endtask
endmodule // dfr_master_model
`default_nettype wire

// *** tb/dfr_register_map_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module dfr_register_map_monitor (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  // Link and drive values
  input wire dfr_pkg::dfr_req_t     req,
  input wire dfr_pkg::dfr_resp_t    resp,
  input wire dfr_pkg::dfr_monitor_t mon,
  // Ramp
  input wire logic [15:0]           rampTime,
  input wire logic                  rampFromLink
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire wrS = req.valid && req.func == 8'h06;
  wire rdM = req.valid && req.func == 8'h03;
  sequence sRampOk;
    wrS && req.regNum == 16'h0004 ##1 resp.exception == 8'h00;
  endsequence
  sequence sSelOk;
    wrS && req.regNum == 16'h01fc ##1 resp.exception == 8'h00;
  endsequence
  AST_ANSWER: assert property (req.valid |=> resp.valid)
    else $error("answer missing");
  AST_RAMP_LIMIT: assert property (wrS && req.regNum == 16'h0004 && req.wdata > 16'hea60
    |=> resp.exception != 8'h00 && $stable(rampTime)) else $error("ramp over limit taken");
  AST_RAMP_STORE: assert property (sRampOk |-> rampTime == $past(req.wdata))
    else $error("ramp not stored");
  AST_RAMP_SELECT: assert property (sSelOk |-> rampFromLink == ($past(req.wdata) == 16'h0001))
    else $error("ramp select wrong");
  AST_STATUS: assert property (rdM && req.regNum == 16'h0006
    |=> resp.rdata == {($past(mon.status.tripped) ? $past(mon.faultCode) : 8'h00), $past(mon.status)})
    else $error("status word wrong");
  AST_FREQ: assert property (rdM && req.regNum == 16'h0007 |=> resp.rdata == $past(mon.outFreq))
    else $error("frequency wrong");
  AST_RO_WRITE: assert property (wrS && req.regNum inside {[16'h0006:16'h0023]} |=> resp.exception == 8'h02)
    else $error("read-only write taken");
  AST_FUNC16: assert property (req.valid && req.func == 8'h10 && req.regNum > 16'h0004
    |=> resp.exception == 8'h01) else $error("multi write accepted");
endmodule // dfr_register_map_monitor
bind dfr_register_map dfr_register_map_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn), .req(req),
  .resp(resp), .mon(mon), .rampTime(rampTime), .rampFromLink(rampFromLink));
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                  clk_sys = 1'b0;
  logic                  rstn = 1'b0;
  dfr_pkg::dfr_req_t     req;
  dfr_pkg::dfr_resp_t    resp;
  dfr_pkg::dfr_monitor_t mon = '0;
  logic [15:0]           rampTime;
  logic                  rampFromLink;
  logic [6:0]            drvParamIdx = 7'h00;
  logic [15:0]           drvParamData;
  logic [7:0]            e;
  logic [15:0]           d;
  int                    n_mismatch = 0;
  int                    cmp_count = 0;
  // Function, register, data, expected answer
  logic [47:0] tbl [13] = '{48'h06000403e804, 48'h0601fb000100, 48'h060004ea6103, 48'h060004ea6000,
    48'h100004006400, 48'h060007123402, 48'h100005000101, 48'h050004000101, 48'h0601f5000202,
    48'h0601f9000700, 48'h06006501f400, 48'h100002000102, 48'h030005000002};
  always #5 clk_sys = ~clk_sys;
  dfr_register_map #(.RUN_LOCK_MASK(100'h1)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .req(req),
    .resp(resp), .mon(mon), .rampTime(rampTime), .rampFromLink(rampFromLink),
    .drvParamIdx(drvParamIdx), .drvParamData(drvParamData));
  dfr_master_model u_master (.clk_sys(clk_sys), .req(req), .resp(resp));
  task automatic chk_d(input logic [15:0] g, input logic [15:0] x);
    cmp_count++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_e(input logic [7:0] g, input logic [7:0] x);
    chk_d({8'h00, g}, {8'h00, x});
  endtask
  task automatic op(input logic [7:0] f, input logic [15:0] r, input logic [15:0] w);
    u_master.xfer(f, r, w, e, d);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    $display("watchdog expired");
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    mon.status = 8'hc3;
    mon.faultCode = 8'h2a;
    for (int i = 0; i < 16; i++)
      mon[255 - 16 * i -: 16] = 16'h1111 * 16'(i) + 16'h0101;
    for (int i = 0; i < 16; i++)
    begin
      op(8'h03, 16'(i < 5 ? 7 + i : i < 10 ? 15 + i : 20 + i), 16'h0000);
      chk_d(d, mon[255 - 16 * i -: 16]);
    end
    op(8'h03, 16'h0006, 16'h0000);
    chk_d(d, 16'h2ac3);
    mon.status = 8'h7c;
    op(8'h03, 16'h0006, 16'h0000);
    chk_d(d, 16'h007c);
    $display("test monitor done");
    for (int i = 0; i < 13; i++)
    begin
      op(tbl[i][47:40], tbl[i][39:24], tbl[i][23:8]);
      chk_e(e, tbl[i][7:0]);
    end
    chk_d(rampTime, 16'h0064);
    op(8'h03, 16'h0004, 16'h0000);
    chk_d(d, 16'h0064);
    chk_d({15'h0000, rampFromLink}, 16'h0000);
    op(8'h06, 16'h01fc, 16'h0001);
    chk_d({15'h0000, rampFromLink}, 16'h0001);
    $display("test access done");
    op(8'h03, 16'h0065, 16'h0000);
    chk_d(d, 16'h01f4);
    drvParamIdx = 7'h54;
    op(8'h03, 16'h01f9, 16'h0000);
    chk_d(d, 16'h0007);
    chk_d(drvParamData, 16'h0007);
    mon.status = 8'h01;
    op(8'h06, 16'h0065, 16'h0001);
    chk_e(e, 8'h04);
    op(8'h03, 16'h0065, 16'h0000);
    chk_d(d, 16'h01f4);
    $display("test params done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
